// file: bench/wdt_cpu_model.sv
// Processor core model issuing bus cycles and stop instructions.
`timescale 1ns/10ps
module wdt_cpu_model (
  input  wire logic        mclk,
  output logic      [15:0] addr,
  output logic      [7:0]  wdata,
  output logic             wr,
  output logic             rd,
  output logic             stop_exec
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  logic [15:0] exp_q [$];

  // The bus starts quiet.
  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    stop_exec = 1'b0;
  end

  // One write cycle; afterwards the bus shows the inverse of its last value.
  task automatic wr_cyc(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr_cyc

  // One read cycle; the note holds the mask in the high byte.
  task automatic rd_cyc(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    addr <= ~a;
  endtask : rd_cyc

  // One stop instruction.
  task automatic stop_cyc();
    @(posedge mclk);
    stop_exec <= 1'b1;
    @(posedge mclk);
    stop_exec <= 1'b0;
  endtask : stop_cyc
endmodule : wdt_cpu_model

// file: bench/wdt_top_properties.sv
// Checker bound to the watchdog top level ports.
`timescale 1ns/10ps
module wdt_top_properties (
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic [15:0] ADDR,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic [7:0]  RESET_VECTOR_LOW,
  input wire logic        WATCHDOG_DISABLE,
  input wire logic        STOP_ENABLE,
  input wire logic        STOP_EXECUTE,
  input wire logic        STOP_MODE,
  input wire logic        MONITOR_MODE,
  input wire logic        EXTERNAL_IRQ_PIN_AT_TEST_VOLTAGE,
  input wire logic        INTERNAL_RESET,
  input wire logic        ILLEGAL_OPCODE_RESET,
  input wire logic        WATCHDOG_CAUSE
);
  // ------------------------------------------------------------
  // Helper logic and properties
  // ------------------------------------------------------------
  logic [7:0] hold_cnt;

  // Counts the cycles for which the internal reset stays high.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_cnt <= 8'h00;
    end else begin
      hold_cnt <= INTERNAL_RESET ? hold_cnt + 8'h01 : 8'h00;
    end
  end

  // All checks sample on the rising clock and rest during reset.
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  property p_vec;
    RD && ADDR == wdt_pkg::SERVICE_ADDR |=> RDATA == $past(RESET_VECTOR_LOW);
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector byte");
  property p_svc;
    WR && ADDR == wdt_pkg::SERVICE_ADDR ##[1:2] RD && ADDR == wdt_pkg::COUNT_ADDR
      |=> RDATA == 8'h00;
  endproperty
  a_svc: assert property (p_svc) else $error("count kept after service");
  property p_stop;
    STOP_MODE [*2] ##0 RD && ADDR == wdt_pkg::PRESC_ADDR |=> RDATA == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("prescaler runs in stop");
  property p_ill;
    STOP_EXECUTE && !STOP_ENABLE |=> ILLEGAL_OPCODE_RESET;
  endproperty
  a_ill: assert property (p_ill) else $error("no illegal opcode reset");
  property p_hold;
    $fell(INTERNAL_RESET) |-> hold_cnt == 8'(wdt_pkg::RESET_HOLD);
  endproperty
  a_hold: assert property (p_hold) else $error("reset length wrong");
  property p_cause;
    $rose(WATCHDOG_CAUSE) |-> $rose(INTERNAL_RESET);
  endproperty
  a_cause: assert property (p_cause) else $error("cause without reset");
  property p_dis;
    WATCHDOG_DISABLE [*2] |=> !$rose(WATCHDOG_CAUSE);
  endproperty
  a_dis: assert property (p_dis) else $error("reset while disabled");
  property p_mon;
    (MONITOR_MODE && EXTERNAL_IRQ_PIN_AT_TEST_VOLTAGE) [*4] |=> !$rose(WATCHDOG_CAUSE);
  endproperty
  a_mon: assert property (p_mon) else $error("reset in monitor mode");
endmodule : wdt_top_properties

bind wdt_top wdt_top_properties chk (
  .MCLK                             (MCLK),
  .RST_N                            (RST_N),
  .ADDR                             (ADDR),
  .WR                               (WR),
  .RD                               (RD),
  .RDATA                            (RDATA),
  .RESET_VECTOR_LOW                 (RESET_VECTOR_LOW),
  .WATCHDOG_DISABLE                 (WATCHDOG_DISABLE),
  .STOP_ENABLE                      (STOP_ENABLE),
  .STOP_EXECUTE                     (STOP_EXECUTE),
  .STOP_MODE                        (STOP_MODE),
  .MONITOR_MODE                     (MONITOR_MODE),
  .EXTERNAL_IRQ_PIN_AT_TEST_VOLTAGE (EXTERNAL_IRQ_PIN_AT_TEST_VOLTAGE),
  .INTERNAL_RESET                   (INTERNAL_RESET),
  .ILLEGAL_OPCODE_RESET             (ILLEGAL_OPCODE_RESET),
  .WATCHDOG_CAUSE                   (WATCHDOG_CAUSE)
);

// file: bench/wdt_top_tb.sv
// Self-checking bench for the watchdog top level.
`timescale 1ns/10ps
module wdt_top_tb;
  // ------------------------------------------------------------
  // Stimulus and checking
  // ------------------------------------------------------------
  localparam int SPAN = wdt_pkg::SHORT_TIMEOUT + 100;
  localparam logic [7:0] MODE_TAB [3] = '{8'h01, 8'h60, 8'h08};
  logic        mclk, rst_n, wr, rd, stop_exec, ires, ill, cause, rd_seen;
  logic [15:0] addr, note;
  logic [7:0]  wdata, rdata, vec_low, cfg;
  int          err_count, samples_checked, rst_seen, ill_seen, n, r0;
  integer      seed;

  // Bits of cfg: disable, rate, stop allowed, stop mode, wait, monitor, test voltage, reset.
  wdt_top uut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RESET_VECTOR_LOW(vec_low), .WATCHDOG_DISABLE(cfg[0]),
    .WATCHDOG_RATE_SELECT(cfg[1]), .STOP_ENABLE(cfg[2]), .STOP_EXECUTE(stop_exec),
    .STOP_MODE(cfg[3]), .WAIT_MODE(cfg[4]), .MONITOR_MODE(cfg[5]),
    .EXTERNAL_IRQ_PIN_AT_TEST_VOLTAGE(cfg[6]), .OTHER_INTERNAL_RESET(cfg[7]),
    .INTERNAL_RESET(ires), .ILLEGAL_OPCODE_RESET(ill), .WATCHDOG_CAUSE(cause));
  wdt_cpu_model cpu (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .stop_exec(stop_exec));

  // Clock of 100 ns period.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Compares one result and reports a difference.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Counts reset pulses and flags a read whose data stands next cycle.
  always @(posedge ires) rst_seen++;
  always @(posedge ill) ill_seen++;
  always @(posedge mclk) rd_seen <= rd;

  // Takes the oldest read note and compares the masked data.
  always @(negedge mclk) begin
    if (rd_seen) begin
      note = cpu.exp_q.pop_front();
      chk(rdata & note[15:8], note[7:0]);
    end
  end

  // Cuts a hung run short.
  initial begin
    #(100 * 90000);
    err_count++;
    summarize();
  end

  // Main sequence of scenarios.
  initial begin
    {err_count, samples_checked, rst_seen, ill_seen} = '0;
    seed = 32'h27e5;
    cfg = 8'h04;
    vec_low = 8'($random(seed));
    rst_n = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    cpu.wr_cyc(wdt_pkg::SERVICE_ADDR, 8'($random(seed)));
    repeat (wdt_pkg::POR_DELAY) @(posedge mclk);
    cpu.rd_cyc(wdt_pkg::SERVICE_ADDR, {8'hff, vec_low});
    cpu.rd_cyc(16'h1234, 16'hff00);
    cfg[1] <= 1'b1;
    r0 = rst_seen;
    for (n = 0; n < 3; n++) begin
      repeat (6000) @(posedge mclk);
      cpu.wr_cyc(wdt_pkg::SERVICE_ADDR, 8'($random(seed)));
      cpu.rd_cyc(wdt_pkg::COUNT_ADDR, 16'hff00);
    end
    chk(8'(rst_seen - r0), 8'h00);
    cfg[4] <= 1'b1;
    cpu.rd_cyc(wdt_pkg::VEC_HIGH_ADDR, 16'h0000);
    n = 0;
    while (!ires && n < 9000) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(n > wdt_pkg::SHORT_TIMEOUT - 3 && n < wdt_pkg::SHORT_TIMEOUT + 3), 8'h01);
    n = 0;
    while (ires && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(n), 8'(wdt_pkg::RESET_HOLD));
    cpu.rd_cyc(wdt_pkg::STATUS_ADDR, 16'h0705);
    cpu.wr_cyc(wdt_pkg::STATUS_ADDR, 8'h01);
    cpu.rd_cyc(wdt_pkg::STATUS_ADDR, 16'h0704);
    cfg[4] <= 1'b0;
    for (n = 0; n < 3; n++) begin
      cpu.wr_cyc(wdt_pkg::SERVICE_ADDR, 8'($random(seed)));
      cfg <= cfg | MODE_TAB[n];
      r0 = rst_seen;
      repeat (SPAN) @(posedge mclk);
      chk(8'(rst_seen - r0), 8'h00);
      cpu.rd_cyc(wdt_pkg::PRESC_ADDR, 16'hff00);
      cpu.rd_cyc(wdt_pkg::COUNT_ADDR, 16'hff00);
      cfg <= cfg & ~MODE_TAB[n];
    end
    repeat (3000) @(posedge mclk);
    r0 = ill_seen;
    cpu.stop_cyc();
    cpu.rd_cyc(wdt_pkg::PRESC_ADDR, 16'hff00);
    cfg[2] <= 1'b0;
    cpu.stop_cyc();
    repeat (80) @(posedge mclk);
    chk(8'(ill_seen - r0), 8'h01);
    chk({7'h00, cause}, 8'h00);
    cfg[2] <= 1'b1;
    repeat (3000) @(posedge mclk);
    cfg[7] <= 1'b1;
    @(posedge mclk);
    cfg[7] <= 1'b0;
    cpu.rd_cyc(wdt_pkg::COUNT_ADDR, 16'hff00);
    cfg[1] <= 1'b0;
    cpu.wr_cyc(wdt_pkg::SERVICE_ADDR, 8'($random(seed)));
    r0 = rst_seen;
    repeat (SPAN) @(posedge mclk);
    chk(8'(rst_seen - r0), 8'h00);
    summarize();
  end
endmodule : wdt_top_tb

// file: include/wdt_if.sv
// Interface joining the watchdog control logic to its timer core.
`timescale 1ns/10ps
interface wdt_if;
  logic                           clr_all;
  logic                           clr_upper;
  logic                           hold_presc;
  logic                           enable;
  logic                           rate_short;
  logic                           overflow;
  logic [wdt_pkg::PRESC_W-1:0]    presc;
  logic [wdt_pkg::CNT_W-1:0]      count;

  modport ctrl (
    output clr_all,
    output clr_upper,
    output hold_presc,
    output enable,
    output rate_short,
    input  overflow,
    input  presc,
    input  count
  );

  modport core (
    input  clr_all,
    input  clr_upper,
    input  hold_presc,
    input  enable,
    input  rate_short,
    output overflow,
    output presc,
    output count
  );
endinterface : wdt_if

// file: include/wdt_pkg.sv
// Package with the watchdog constants, register map and state types.
package wdt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 8;
  localparam int PRESC_W  = 12;
  localparam int CNT_W    = 6;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] SERVICE_ADDR  = 16'hffff;
  localparam logic [15:0] VEC_HIGH_ADDR = 16'hfffe;
  localparam logic [15:0] STATUS_ADDR   = 16'hfe01;
  localparam logic [15:0] COUNT_ADDR    = 16'hfe02;
  localparam logic [15:0] PRESC_ADDR    = 16'hfe03;

  // Status register field positions.
  localparam int ST_WDT_CAUSE = 0;
  localparam int ST_ILLOP     = 1;
  localparam int ST_POR_DONE  = 2;
  localparam int ST_RST_BUSY  = 3;
  localparam int ST_ENABLED   = 4;
  localparam int ST_STOPPED   = 5;

  // Reset values.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Timing counts in oscillator cycles
  // ----------------------------------------------------------------
  localparam int LONG_TIMEOUT   = 2**18 - 2**4;
  localparam int SHORT_TIMEOUT  = 2**13 - 2**4;
  localparam int SERVICE_LOW_W  = 4;
  localparam int RESET_HOLD     = 64;
  localparam int POR_DELAY      = 4096;
  localparam int LONG_TAP       = 11;
  localparam int SHORT_TAP      = 6;

  // ----------------------------------------------------------------
  // Reset generator states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDT_RS_IDLE = 2'b01,
    WDT_RS_HOLD = 2'b10
  } wdt_rst_state_t;

endpackage : wdt_pkg

// file: src/wdt_core.sv
// Watchdog timer core: 12-bit prescaler feeding a 6-bit counter.
`timescale 1ns/10ps
module wdt_core #(
  parameter int PW = wdt_pkg::PRESC_W,
  parameter int CW = wdt_pkg::CNT_W
) (
  input wire logic MCLK,
  input wire logic RST_N,
  wdt_if.core      tif
);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [PW-1:0] presc;
  logic [CW-1:0] count;
  logic [PW:0]   next_presc;
  logic          tap_carry;
  logic          at_end;

  assign next_presc = {1'b0, presc} + {{PW{1'b0}}, 1'b1};

  // Carry out of the selected prescaler stage drives the counter.
  assign tap_carry = tif.rate_short ?
    (presc[wdt_pkg::SHORT_TAP:0] == '1) : (presc[wdt_pkg::LONG_TAP:0] == '1);

  // Prescaler: full clear, upper clear on service, hold in stop.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      presc <= '0;
    end else if (tif.clr_all || tif.hold_presc || !tif.enable) begin
      presc <= '0;
    end else if (tif.clr_upper) begin
      presc <= {{(PW-wdt_pkg::SERVICE_LOW_W){1'b0}}, presc[wdt_pkg::SERVICE_LOW_W-1:0]};
    end else begin
      presc <= next_presc[PW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter and overflow
  // ----------------------------------------------------------------
  // Counter advances only on the prescaler carry; clears take priority.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      count <= '0;
    end else if (tif.clr_all || tif.clr_upper || !tif.enable) begin
      count <= '0;
    end else if (!tif.hold_presc && tap_carry) begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Overflow fires 16 cycles short of the full tap period times 64.
  assign at_end = tif.rate_short ?
    (presc[wdt_pkg::SHORT_TAP:0] == '1 - 7'(16)) :
    (presc[wdt_pkg::LONG_TAP:0] == '1 - 12'(16));

  assign tif.overflow = tif.enable && !tif.clr_all && !tif.clr_upper &&
                        !tif.hold_presc && (count == '1) && at_end;
  assign tif.presc    = presc;
  assign tif.count    = count;

endmodule : wdt_core

// file: src/wdt_top.sv
// Watchdog top level: bus access, reset control and condition inputs.
//
// Function
// - Six-bit free-running counter clocked by twelve-bit prescaler carry.
// - Counter overflow raises reset after the selected timeout length.
// - Any write to service address clears counter and prescaler stages five to twelve.
// - Service address is topmost; reads return reset vector low byte.
// - Watchdog reset drives internal reset 64 cycles and sets cause flag.
// - Monitor mode with test voltage on interrupt pin disables watchdog.
// - Stop instruction execution clears the prescaler.
// - Power-on circuit clears prescaler 4096 cycles after power-up.
// - Any internal reset clears prescaler and counter.
// - Reset vector fetch seen on the bus clears the prescaler.
// - Disable and rate inputs follow configuration register bits directly.
// - Watchdog never raises an interrupt; only reset on timeout.
// - Watchdog keeps counting during wait mode.
// - Stop mode holds prescaler in reset until stop mode ends.
// - Stop instruction while stop is disabled gives illegal-opcode reset.
// - Watchdog runs on the oscillator clock of the clock generator.
// - Rate select one gives short timeout, zero long; reset clears it (here WATCHDOG_RATE_SELECT is used directly and no reset clears it).
// - Disable value one turns watchdog off; zero leaves it on.
`timescale 1ns/10ps
module wdt_top #(
  parameter int AW = wdt_pkg::ADDR_W,
  parameter int DW = wdt_pkg::DATA_W
) (
  input  wire logic          MCLK,
  input  wire logic          RST_N,
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [DW-1:0] WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [DW-1:0] RDATA,
  input  wire logic [DW-1:0] RESET_VECTOR_LOW,
  input  wire logic          WATCHDOG_DISABLE,
  input  wire logic          WATCHDOG_RATE_SELECT,
  input  wire logic          STOP_ENABLE,
  input  wire logic          STOP_EXECUTE,
  input  wire logic          STOP_MODE,
  input  wire logic          WAIT_MODE,
  input  wire logic          MONITOR_MODE,
  input  wire logic          EXTERNAL_IRQ_PIN_AT_TEST_VOLTAGE,
  input  wire logic          OTHER_INTERNAL_RESET,
  output logic               INTERNAL_RESET,
  output logic               ILLEGAL_OPCODE_RESET,
  output logic               WATCHDOG_CAUSE
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wdt_if tif ();

  logic                        mon_meta;
  logic                        mon_sync;
  logic                        tv_meta;
  logic                        tv_sync;
  logic                        test_disable;
  logic                        service_pulse;
  logic                        vector_fetch;
  logic                        illop_event;
  logic                        wdt_enabled;
  logic                        por_clear;
  logic                        por_done;
  logic [12:0]                 por_cnt;
  logic [6:0]                  hold_cnt;
  wdt_pkg::wdt_rst_state_t     rst_state;
  wdt_pkg::wdt_rst_state_t     next_rst_state;
  logic                        illop_flag;
  logic                        cause_clear;
  logic                        illop_clear;
  logic [DW-1:0]               status;
  logic [DW-1:0]               next_rdata;
  logic                        any_int_reset;

  // ----------------------------------------------------------------
  // Monitor-mode input synchronisers
  // ----------------------------------------------------------------
  // Monitor mode and the pin level come from outside, so two stages each.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mon_meta <= 1'b0;
      mon_sync <= 1'b0;
      tv_meta  <= 1'b0;
      tv_sync  <= 1'b0;
    end else begin
      mon_meta <= MONITOR_MODE;
      mon_sync <= mon_meta;
      tv_meta  <= EXTERNAL_IRQ_PIN_AT_TEST_VOLTAGE;
      tv_sync  <= tv_meta;
    end
  end

  assign test_disable = mon_sync && tv_sync;

  // ----------------------------------------------------------------
  // Enable and rate
  // ----------------------------------------------------------------
  // configuration bits used directly.
  assign wdt_enabled = !WATCHDOG_DISABLE && !test_disable;

  assign tif.rate_short = WATCHDOG_RATE_SELECT;
  assign tif.enable     = wdt_enabled;

  // ----------------------------------------------------------------
  // Bus event decode
  // ----------------------------------------------------------------
  // one-cycle service detect.
  assign service_pulse = WR && (ADDR == wdt_pkg::SERVICE_ADDR);

  // vector fetch detected on the address bus.
  assign vector_fetch = RD && ((ADDR == wdt_pkg::VEC_HIGH_ADDR) ||
                               (ADDR == wdt_pkg::SERVICE_ADDR));

  // stop while disabled becomes illegal opcode.
  assign illop_event = STOP_EXECUTE && !STOP_ENABLE;

  // ----------------------------------------------------------------
  // Power-on delay
  // ----------------------------------------------------------------
  // count 4096 cycles after power-up, then clear once.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      por_cnt  <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      if (por_cnt == 13'(wdt_pkg::POR_DELAY - 1)) begin
        por_done <= 1'b1;
      end
      por_cnt <= por_cnt + 13'h0001;
    end
  end

  assign por_clear = !por_done && (por_cnt == 13'(wdt_pkg::POR_DELAY - 1));

  // ----------------------------------------------------------------
  // Internal reset generator
  // ----------------------------------------------------------------
  // Next-state logic of the reset hold machine.
  always_comb begin
    next_rst_state = rst_state;
    case (rst_state)
      wdt_pkg::WDT_RS_IDLE: begin
        if (tif.overflow || illop_event) begin
          next_rst_state = wdt_pkg::WDT_RS_HOLD;
        end
      end
      wdt_pkg::WDT_RS_HOLD: begin
        if (hold_cnt == 7'(wdt_pkg::RESET_HOLD - 1)) begin
          next_rst_state = wdt_pkg::WDT_RS_IDLE;
        end
      end
      default: begin
        next_rst_state = wdt_pkg::WDT_RS_IDLE;
      end
    endcase
  end

  // State register of the reset hold machine.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_state <= wdt_pkg::WDT_RS_IDLE;
    end else begin
      rst_state <= next_rst_state;
    end
  end

  // hold internal reset for 64 cycles.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_cnt <= '0;
    end else if (rst_state == wdt_pkg::WDT_RS_HOLD) begin
      hold_cnt <= hold_cnt + 7'h01;
    end else begin
      hold_cnt <= '0;
    end
  end

  // Reset output is a register decode of the state.
  assign INTERNAL_RESET = (rst_state == wdt_pkg::WDT_RS_HOLD);
  assign any_int_reset  = INTERNAL_RESET || OTHER_INTERNAL_RESET;

  // ----------------------------------------------------------------
  // Timer core control
  // ----------------------------------------------------------------
  // internal reset clears both stages.
  assign tif.clr_all    = any_int_reset || por_clear || vector_fetch ||
                          (STOP_EXECUTE && STOP_ENABLE);
  assign tif.hold_presc = STOP_MODE;
  assign tif.clr_upper  = service_pulse;

  // prescaler and counter in the core.
  // core runs on the oscillator clock.
  // wait mode does not gate counting.
  wdt_core #(
    .PW (wdt_pkg::PRESC_W),
    .CW (wdt_pkg::CNT_W)
  ) u_core (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .tif   (tif.core)
  );

  // ----------------------------------------------------------------
  // Reset cause flags
  // ----------------------------------------------------------------
  // Writing one to the cause or illegal-opcode status bit clears that flag.
  assign cause_clear = WR && (ADDR == wdt_pkg::STATUS_ADDR) && WDATA[wdt_pkg::ST_WDT_CAUSE];
  assign illop_clear = WR && (ADDR == wdt_pkg::STATUS_ADDR) && WDATA[wdt_pkg::ST_ILLOP];

  // cause flag set on watchdog reset; set beats clear.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      WATCHDOG_CAUSE <= 1'b0;
    end else if (tif.overflow) begin
      WATCHDOG_CAUSE <= 1'b1;
    end else if (cause_clear) begin
      WATCHDOG_CAUSE <= 1'b0;
    end
  end

  // illegal opcode flag and reset pulse.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      illop_flag           <= 1'b0;
      ILLEGAL_OPCODE_RESET <= 1'b0;
    end else begin
      ILLEGAL_OPCODE_RESET <= illop_event;
      if (illop_event) begin
        illop_flag <= 1'b1;
      end else if (illop_clear) begin
        illop_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Status word gathered from live block state.
  always_comb begin
    status                        = wdt_pkg::STATUS_RESET;
    status[wdt_pkg::ST_WDT_CAUSE] = WATCHDOG_CAUSE;
    status[wdt_pkg::ST_ILLOP]     = illop_flag;
    status[wdt_pkg::ST_POR_DONE]  = por_done;
    status[wdt_pkg::ST_RST_BUSY]  = INTERNAL_RESET;
    status[wdt_pkg::ST_ENABLED]   = wdt_enabled;
    status[wdt_pkg::ST_STOPPED]   = STOP_MODE && !WAIT_MODE;
  end

  // Read data selection; unmapped addresses read as zero.
  always_comb begin
    next_rdata = wdt_pkg::READ_UNMAPPED;
    case (ADDR)
      // service address reads vector low byte.
      wdt_pkg::SERVICE_ADDR: next_rdata = RESET_VECTOR_LOW;
      wdt_pkg::STATUS_ADDR:  next_rdata = status;
      wdt_pkg::COUNT_ADDR:   next_rdata = {2'b00, tif.count};
      wdt_pkg::PRESC_ADDR:   next_rdata = tif.presc[11:4];
      default:               next_rdata = wdt_pkg::READ_UNMAPPED;
    endcase
  end

  // Read data register, valid only in the cycle after the strobe.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= '0;
    end
  end

endmodule : wdt_top
